// file: rtl/gp_io_port.sv
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps
`default_nettype none

// Contract
// - The direction register is 8 bits, write-only, and a read of it returns a filler value, not its bits.
// - A direction bit at 1 makes its pin an output and at 0 makes it an input.
// - Power-on reset and hardware standby clear all direction bits so every pin is an input.
// - While manual reset is asserted the pins are decided by the direction and output data registers alone.
// - The output data register is an 8-bit read/write latch driving pins 7 to 0 when they are outputs.
// - Power-on reset and hardware standby clear the output data register to zero.
// - Manual reset and software standby keep the direction and output data registers unchanged.
// - The pin-state register is read-only and ignores writes; software writes outputs to the data latch.
// - A port read returns the latch bit where the direction bit is 1.
// - A port read returns the sampled pin level where the direction bit is 0.
// - Pin-state readback follows the pins after power-on or in hardware standby and holds through manual reset or software standby.
// - Direction, output data and pin-state registers decode at FEB5, FF65 and FF55.
// - Pins 5, 4 and 2 have the same functions in every mode; pins 7, 6, 1 and 0 change with the mode, and pins 3 and 1 with the end-of-transfer enable.
module gp_io_port
  import gp_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic hw_standby_in,
  input wire logic manual_rst_in,
  input wire logic sw_standby_in,
  input wire logic [GP_ADDR_W-1:0] addr_in,
  input wire logic [GP_WIDTH-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [GP_WIDTH-1:0] rdata_out,
  input wire logic expanded_mode_in,
  input wire logic [3:0] cs_n_in,
  input wire logic [1:0] tend_en_in,
  input wire logic [1:0] tend_n_in,
  input wire logic [GP_WIDTH-1:0] pin_in,
  output logic [GP_WIDTH-1:0] pin_out,
  output logic [GP_WIDTH-1:0] pin_oe_out,
  output logic [3:0] irq_level_out,
  output logic [1:0] dreq_level_out
);

  gp_bus_req_t req;
  gp_alt_t alt;

  logic [GP_WIDTH-1:0] direction;
  logic [GP_WIDTH-1:0] output_data;
  logic [GP_WIDTH-1:0] pin_state;
  logic [GP_WIDTH-1:0] pin_level;

  logic [GP_WIDTH-1:0] next_direction;
  logic [GP_WIDTH-1:0] next_output_data;
  logic [GP_WIDTH-1:0] next_pin_state;
  logic [GP_WIDTH-1:0] next_rdata;
  logic [GP_WIDTH-1:0] next_pin_out;
  logic [GP_WIDTH-1:0] next_pin_oe;
  logic [3:0] next_irq_level;
  logic [1:0] next_dreq_level;
  logic [GP_WIDTH-1:0] port_read;

  logic sel_direction;
  logic sel_output_data;
  logic sel_pin_state;
  logic hold_readback;
  logic alt_allowed;

  assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};
  assign alt = '{expanded_mode: expanded_mode_in, cs_n: cs_n_in, tend_en: tend_en_in, tend_n: tend_n_in};

  gp_pin_sync u_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .clk_en_in(clk_en_in),
    .pin_in(pin_in),
    .level_out(pin_level)
  );

  // Address decode
  always_comb begin
    sel_direction = (req.addr == GP_ADDR_DIRECTION);
    sel_output_data = (req.addr == GP_ADDR_OUTPUT_DATA);
    sel_pin_state = (req.addr == GP_ADDR_PIN_STATE);
  end

  // Register state
  always_comb begin
    next_direction = direction;
    next_output_data = output_data;
    // Standby clear wins over a write in the same cycle
    if (hw_standby_in) begin
      next_direction = GP_DIRECTION_RESET;
      next_output_data = GP_OUTPUT_DATA_RESET;
    end else begin
      // Manual reset and software standby simply leave both registers alone
      if (req.wr && sel_direction) begin
        next_direction = req.wdata;
      end
      if (req.wr && sel_output_data) begin
        next_output_data = req.wdata;
      end
      // Writes to the pin-state address fall through with no effect
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      direction <= GP_DIRECTION_RESET;
      output_data <= GP_OUTPUT_DATA_RESET;
    end else if (clk_en_in) begin
      direction <= next_direction;
      output_data <= next_output_data;
    end
  end

  // Pin-state readback
  always_comb begin
    hold_readback = (manual_rst_in || sw_standby_in) && !hw_standby_in;
    next_pin_state = hold_readback ? pin_state : pin_level;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pin_state <= GP_DIRECTION_RESET;
    end else if (clk_en_in) begin
      pin_state <= next_pin_state;
    end
  end

  // Read path
  always_comb begin
    port_read = (direction & output_data) | (~direction & pin_state);
    next_rdata = GP_RDATA_IDLE;
    if (req.rd) begin
      if (sel_direction) begin
        next_rdata = GP_UNDEF_READ;
      end else if (sel_output_data) begin
        next_rdata = output_data;
      end else if (sel_pin_state) begin
        next_rdata = port_read;
      end else begin
        next_rdata = GP_UNMAPPED_READ;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rdata_out <= GP_RDATA_IDLE;
    end else if (clk_en_in) begin
      rdata_out <= next_rdata;
    end
  end

  // Pin drive
  // The DMA and bus controller are reinitialised by a manual reset, so their
  // pin functions are cut off here rather than trusted to be idle.
  always_comb begin
    alt_allowed = !manual_rst_in && !hw_standby_in;
  end

  genvar i;
  generate
    for (i = 0; i < GP_WIDTH; i++) begin : g_pin
      // Indices folded into range on pins that never use them
      localparam int CS_IDX = (i >= 6) ? i - 4 : i % 2;
      localparam int TEND_IDX = (i / 2) % 2;
      always_comb begin
        next_pin_out[i] = output_data[i];
        next_pin_oe[i] = direction[i];
        if (GP_TEND_PIN_MASK[i] && alt_allowed && alt.tend_en[TEND_IDX]) begin
          next_pin_out[i] = alt.tend_n[TEND_IDX];
          next_pin_oe[i] = 1'b1;
        end else if (GP_CS_PIN_MASK[i] && alt_allowed && alt.expanded_mode && direction[i]) begin
          next_pin_out[i] = alt.cs_n[CS_IDX];
        end
      end
    end
  endgenerate

  // Interrupt and request inputs see the pin whatever the direction
  always_comb begin
    next_irq_level = pin_level[GP_BIT_IRQ0 +: 4];
    next_dreq_level = {pin_level[GP_BIT_DREQ1], pin_level[GP_BIT_DREQ0]};
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pin_out <= GP_OUTPUT_DATA_RESET;
      pin_oe_out <= GP_DIRECTION_RESET;
      irq_level_out <= '0;
      dreq_level_out <= '0;
    end else if (clk_en_in) begin
      pin_out <= next_pin_out;
      pin_oe_out <= next_pin_oe;
      irq_level_out <= next_irq_level;
      dreq_level_out <= next_dreq_level;
    end
  end

  // Checks
  logic live;
  assign live = rst_n_in && clk_en_in;

  por_clear_a: assert property (
    @(posedge clk_in) !rst_n_in |=> (direction == 8'h00) && (output_data == 8'h00) && (pin_oe_out == 8'h00)
  ) else $error("power-on reset did not clear the port");

  hws_clear_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    live && hw_standby_in |=> (direction == 8'h00) && (output_data == 8'h00)
  ) else $error("hardware standby did not clear the port");

  hws_inputs_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (live && hw_standby_in) [*2] |=> pin_oe_out == 8'h00
  ) else $error("pin driven during hardware standby");

  keep_manual_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    live && (manual_rst_in || sw_standby_in) && !hw_standby_in && !wr_in |=> $stable(direction) && $stable(output_data)
  ) else $error("registers changed during manual reset or software standby");

  dir_write_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    live && !hw_standby_in && wr_in && addr_in == 16'hfeb5 ##1 live && !manual_rst_in && !hw_standby_in && tend_en_in == 2'b00
    |=> pin_oe_out == $past(wdata_in, 2)
  ) else $error("direction write did not reach the pin enables");

  dir_read_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    live && rd_in && addr_in == 16'hfeb5 |=> rdata_out == GP_UNDEF_READ
  ) else $error("direction read exposed stored bits");

  data_read_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    live && rd_in && addr_in == 16'hff65 |=> rdata_out == $past(output_data)
  ) else $error("output data read wrong");

  read_mix_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    live && rd_in && addr_in == 16'hff55
    |=> rdata_out == (($past(direction) & $past(output_data)) | (~$past(direction) & $past(pin_state)))
  ) else $error("port read did not mix latch and pins per bit");

  pin_ro_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    live && wr_in && addr_in == 16'hff55 && !hw_standby_in |=> $stable(direction) && $stable(output_data)
  ) else $error("pin-state write changed a register");

  hold_state_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    live && (manual_rst_in || sw_standby_in) && !hw_standby_in |=> $stable(pin_state)
  ) else $error("readback moved during a hold");

  manual_plain_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    live && manual_rst_in |=> pin_out == $past(output_data) && pin_oe_out == $past(direction)
  ) else $error("alternate function active through manual reset");

  fixed_pins_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    live |=> pin_out[5:4] == $past(output_data[5:4]) && pin_out[2] == $past(output_data[2])
  ) else $error("mode-independent pins changed function");

  idle_read_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    live && !rd_in |=> rdata_out == 8'h00
  ) else $error("read data stood outside its cycle");

  data_write_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    live && !hw_standby_in && wr_in && addr_in == 16'hff65 |=> output_data == $past(wdata_in)
  ) else $error("output data write did not land");

  oe_follow_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    live && tend_en_in == 2'b00 |=> pin_oe_out == $past(direction)
  ) else $error("pin enables did not follow the direction bits");

  tend_out_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    live && alt_allowed && tend_en_in[0] |=> pin_oe_out[1] && pin_out[1] == $past(tend_n_in[0])
  ) else $error("end-of-transfer output not driven");

  cs_out_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    live && alt_allowed && expanded_mode_in && direction[7] |=> pin_out[7] == $past(cs_n_in[3])
  ) else $error("chip select not driven on its pin");

  plain_mode_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    live && !expanded_mode_in && tend_en_in == 2'b00 |=> pin_out == $past(output_data)
  ) else $error("alternate output active in single-chip mode");

  follow_pins_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    live && (hw_standby_in || !(manual_rst_in || sw_standby_in)) |=> pin_state == $past(pin_level)
  ) else $error("readback did not follow the pins");

  irq_follow_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    live |=> irq_level_out == $past(pin_level[7:4])
    && dreq_level_out == {$past(pin_level[2]), $past(pin_level[0])}
  ) else $error("request inputs did not follow the pins");

  unmapped_read_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    live && rd_in && addr_in != 16'hfeb5 && addr_in != 16'hff65 && addr_in != 16'hff55 |=> rdata_out == 8'h00
  ) else $error("unmapped read returned data");

  // A low enable must freeze everything, the read data included
  freeze_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !clk_en_in |=> $stable(direction) && $stable(output_data) && $stable(pin_state) && $stable(rdata_out)
  ) else $error("state moved with the clock enable low");

  mixed_read_c: cover property (
    @(posedge clk_in) disable iff (!rst_n_in)
    live && rd_in && addr_in == 16'hff55 && direction != 8'h00 && direction != 8'hff
  );

  manual_rst_c: cover property (
    @(posedge clk_in) disable iff (!rst_n_in)
    live && manual_rst_in && direction != 8'h00
  );

  hw_standby_c: cover property (
    @(posedge clk_in) disable iff (!rst_n_in)
    live && hw_standby_in && output_data != 8'h00
  );

  tend_drive_c: cover property (
    @(posedge clk_in) disable iff (!rst_n_in)
    live && alt_allowed && tend_en_in != 2'b00
  );

  cs_select_c: cover property (
    @(posedge clk_in) disable iff (!rst_n_in)
    live && alt_allowed && expanded_mode_in && direction[7]
  );

endmodule

`default_nettype wire

// file: common/gp_pkg.sv
package gp_pkg;

  localparam int GP_WIDTH = 8;
  localparam int GP_ADDR_W = 16;
  localparam int GP_SYNC_STAGES = 3;

  // Register addresses (lower 16 bits)
  localparam logic [15:0] GP_ADDR_DIRECTION = 16'hfeb5;
  localparam logic [15:0] GP_ADDR_OUTPUT_DATA = 16'hff65;
  localparam logic [15:0] GP_ADDR_PIN_STATE = 16'hff55;

  // Values after reset
  localparam logic [7:0] GP_DIRECTION_RESET = 8'h00;
  localparam logic [7:0] GP_OUTPUT_DATA_RESET = 8'h00;
  localparam logic [7:0] GP_RDATA_IDLE = 8'h00;
  localparam logic [7:0] GP_UNMAPPED_READ = 8'h00;
  // Direction register reads back a fixed filler, never its bits
  localparam logic [7:0] GP_UNDEF_READ = 8'ha5;

  // Pins carrying chip selects in expanded modes, end-of-transfer outputs and interrupt inputs
  localparam logic [7:0] GP_CS_PIN_MASK = 8'hc3;
  localparam logic [7:0] GP_TEND_PIN_MASK = 8'h0a;
  localparam logic [7:0] GP_IRQ_PIN_MASK = 8'hf0;

  // Alternate-function pin positions
  localparam int GP_BIT_IRQ0 = 4;
  localparam int GP_BIT_DREQ0 = 0;
  localparam int GP_BIT_DREQ1 = 2;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } gp_bus_req_t;

  typedef struct packed {
    logic expanded_mode;
    logic [3:0] cs_n;
    logic [1:0] tend_en;
    logic [1:0] tend_n;
  } gp_alt_t;

endpackage

// file: rtl/gp_pin_sync.sv
`timescale 1ns/10ps
`default_nettype none

module gp_pin_sync
  import gp_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic [GP_WIDTH-1:0] pin_in,
  output logic [GP_WIDTH-1:0] level_out
);

  logic [GP_WIDTH-1:0] stage1;
  logic [GP_WIDTH-1:0] stage2;
  logic [GP_WIDTH-1:0] stage3;
  logic [GP_WIDTH-1:0] next_level;

  genvar i;
  generate
    for (i = 0; i < GP_WIDTH; i++) begin : g_bit
      // A change counts only once the two later stages agree
      always_comb begin
        next_level[i] = (stage2[i] == stage3[i]) ? stage3[i] : level_out[i];
      end
    end
  endgenerate

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      level_out <= '0;
    end else if (clk_en_in) begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
      level_out <= next_level;
    end
  end

endmodule

`default_nettype wire

// file: dv/gp_pin_board.sv
`timescale 1ns/10ps
`default_nettype none

module gp_pin_board
  import gp_pkg::*;
(
  input wire logic [GP_WIDTH-1:0] pin_out_in,
  input wire logic [GP_WIDTH-1:0] pin_oe_in,
  input wire logic [GP_WIDTH-1:0] ext_level_in,
  output logic [GP_WIDTH-1:0] pin_level_out
);
  // Board lets go of any line the port drives, so no contention
  assign pin_level_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & ext_level_in);
endmodule

`default_nettype wire

// file: dv/gp_io_port_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module gp_io_port_tb_top
  import gp_pkg::*;
;
  logic clk_in, rst_n_in, hw_sb, man_rst, sw_sb, wr, rd, exp_mode, rd_d, ce;
  logic [15:0] addr;
  logic [7:0] wdata, rdata, lvl, pout, poe, ext, dir, dat, v;
  logic [3:0] cs_n, irq;
  logic [1:0] tend_en, tend_n, dreq;
  logic [7:0] exp_q[$];
  int err_total, n_checks;

  gp_io_port dut_u (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .clk_en_in(ce), .hw_standby_in(hw_sb),
    .manual_rst_in(man_rst), .sw_standby_in(sw_sb), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .expanded_mode_in(exp_mode), .cs_n_in(cs_n),
    .tend_en_in(tend_en), .tend_n_in(tend_n), .pin_in(lvl), .pin_out(pout), .pin_oe_out(poe),
    .irq_level_out(irq), .dreq_level_out(dreq)
  );

  gp_pin_board board_u (.pin_out_in(pout), .pin_oe_in(poe), .ext_level_in(ext), .pin_level_out(lvl));

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] expv);
    n_checks++;
    if (seen !== expv) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, expv, seen);
    end
  endtask

  task automatic stop_test;
    if (exp_q.size() != 0) err_total++;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_in);
    rd <= 1'b1;
    addr <= a;
    exp_q.push_back(e);
    @(posedge clk_in);
    rd <= 1'b0;
  endtask

  // Read data only stand in the cycle after the strobe, so sample mid-cycle
  always @(posedge clk_in) rd_d <= rd;
  always @(negedge clk_in) begin
    if (rd_d) begin
      if (exp_q.size() == 0) check("unexpected read", rdata, 8'h00);
      else check("rdata", rdata, exp_q.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    err_total++;
    $display("[FAIL] watchdog expected end seen hang");
    stop_test();
  end

  initial begin
    rst_n_in = 1'b0; hw_sb = 1'b0; man_rst = 1'b0; sw_sb = 1'b0; wr = 1'b0; rd = 1'b0;
    exp_mode = 1'b0; ce = 1'b1; addr = 16'h0000; wdata = 8'h00; cs_n = 4'hf;
    tend_en = 2'b00; tend_n = 2'b11; ext = 8'h00; err_total = 0; n_checks = 0;
    void'($urandom(62));
    tick(12);
    rst_n_in <= 1'b1;
    ext <= 8'($urandom);
    tick(6);
    check("oe after reset", poe, 8'h00);
    bus_rd(GP_ADDR_OUTPUT_DATA, GP_OUTPUT_DATA_RESET);
    bus_rd(GP_ADDR_PIN_STATE, ext);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      dir = 8'($urandom);
      dat = 8'($urandom);
      bus_wr(GP_ADDR_DIRECTION, dir);
      bus_wr(GP_ADDR_OUTPUT_DATA, dat);
      ext <= 8'($urandom);
      // Pin to request output takes five edges; look after they settle
      tick(8);
      check("pin_oe", poe, dir);
      check("pin_out", pout, dat);
      check("irq", {4'h0, irq}, {4'h0, lvl[7:4]});
      check("dreq", {6'h00, dreq}, {6'h00, lvl[2], lvl[0]});
      bus_rd(GP_ADDR_DIRECTION, GP_UNDEF_READ);
      bus_rd(GP_ADDR_OUTPUT_DATA, dat);
      bus_rd(GP_ADDR_PIN_STATE, (dir & dat) | (~dir & ext));
      bus_wr(GP_ADDR_PIN_STATE, ~dat);
      bus_rd(GP_ADDR_OUTPUT_DATA, dat);
      bus_rd(16'hff56, GP_UNMAPPED_READ);
    end
    $display("test mixed done");
    bus_wr(GP_ADDR_DIRECTION, 8'hff);
    exp_mode <= 1'b1;
    cs_n <= 4'($urandom);
    tick(3);
    check("cs pins", pout, {cs_n[3], cs_n[2], dat[5:2], cs_n[1], cs_n[0]});
    // Manual reset must hide both the chip selects and the end-of-transfer drive
    man_rst <= 1'b1;
    tend_en <= 2'b11;
    tend_n <= {~dat[3], ~dat[1]};
    tick(3);
    check("manual pins", pout, dat);
    bus_rd(GP_ADDR_OUTPUT_DATA, dat);
    man_rst <= 1'b0;
    tick(3);
    check("tend oe", poe & 8'h0a, 8'h0a);
    check("tend out", pout & 8'h0a, {4'h0, ~dat[3], 1'b0, ~dat[1], 1'b0});
    tend_en <= 2'b00;
    exp_mode <= 1'b0;
    $display("test modes done");
    v = 8'($urandom);
    bus_wr(GP_ADDR_DIRECTION, 8'h00);
    ext <= v;
    tick(6);
    sw_sb <= 1'b1;
    ext <= ~v;
    tick(6);
    bus_rd(GP_ADDR_PIN_STATE, v);
    bus_rd(GP_ADDR_OUTPUT_DATA, dat);
    sw_sb <= 1'b0;
    man_rst <= 1'b1;
    tick(6);
    bus_rd(GP_ADDR_PIN_STATE, v);
    man_rst <= 1'b0;
    tick(6);
    bus_rd(GP_ADDR_PIN_STATE, ~v);
    $display("test standby hold done");
    bus_wr(GP_ADDR_DIRECTION, 8'hff);
    hw_sb <= 1'b1;
    bus_wr(GP_ADDR_OUTPUT_DATA, 8'h5a);
    tick(2);
    hw_sb <= 1'b0;
    bus_rd(GP_ADDR_OUTPUT_DATA, GP_OUTPUT_DATA_RESET);
    tick(2);
    check("oe after standby", poe, GP_DIRECTION_RESET);
    bus_wr(GP_ADDR_DIRECTION, 8'hff);
    bus_wr(GP_ADDR_OUTPUT_DATA, 8'h3c);
    rst_n_in <= 1'b0;
    tick(2);
    rst_n_in <= 1'b1;
    bus_rd(GP_ADDR_OUTPUT_DATA, GP_OUTPUT_DATA_RESET);
    tick(2);
    check("oe after second reset", poe, GP_DIRECTION_RESET);
    // A write made with the clock enable low must be lost
    ce <= 1'b0;
    bus_wr(GP_ADDR_OUTPUT_DATA, 8'h77);
    ce <= 1'b1;
    bus_rd(GP_ADDR_OUTPUT_DATA, GP_OUTPUT_DATA_RESET);
    $display("test clears done");
    tick(4);
    stop_test();
  end
endmodule

`default_nettype wire
